//--- src/uefs_defines.svh
// constants for the event flag enable select block
`ifndef UEFS_DEFINES_SVH
`define UEFS_DEFINES_SVH
`define UEFS_ADDR_W          7
`define UEFS_OFS_READY_EN    7'h12
`define UEFS_OFS_NREADY_EN   7'h14
`define UEFS_OFS_SELECT      7'h10
`define UEFS_SEL_CFG         5
`define UEFS_SEL_SUSPEND     4
`define UEFS_SEL_WR_STATUS   3
`define UEFS_SEL_RD_STATUS   2
`define UEFS_SEL_DONE        1
`define UEFS_SEL_SEQ_ERR     0
`define UEFS_SEL_W           6
`define UEFS_RESET_VAL       16'h0000
`endif

//--- src/uefs_pkg.sv
// types for the event flag enable select block
package uefs_pkg;
    typedef logic [15:0] uefs_word_t;
endpackage

//--- src/uefs_enable_select.sv
// enable selection for usb device state, control stage and endpoint summary flags
`timescale 1ns/1ps
`default_nettype none
`include "uefs_defines.svh"
module uefs_enable_select #(
    parameter int NUM_EP = 7 // endpoints served
) (
    // clock and reset
    input  wire logic                    clk,
    input  wire logic                    rst_b,
    input  wire logic                    soft_reset,       // software reset pulse
    // register port
    input  wire logic [`UEFS_ADDR_W-1:0] reg_addr,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    input  wire uefs_pkg::uefs_word_t    reg_wdata,
    output var   uefs_pkg::uefs_word_t   reg_rdata,
    // event pulses from the protocol engine
    input  wire logic                    ev_set_config,
    input  wire logic                    ev_suspend,
    input  wire logic                    ev_write_status,
    input  wire logic                    ev_read_status,
    input  wire logic                    ev_status_done,
    input  wire logic                    ev_sequence_error,
    input  wire logic                    ev_setup_done,
    // endpoint flags from the buffer manager
    input  wire logic [NUM_EP-1:0]       per_endpoint_ready_flags,
    input  wire logic [NUM_EP-1:0]       per_endpoint_not_ready_flags,
    // interrupt enables held elsewhere
    input  wire logic                    ready_irq_enable,
    input  wire logic                    not_ready_irq_enable,
    input  wire logic                    device_state_irq_enable,
    input  wire logic                    control_stage_irq_enable,
    // summary flag set pulses and irq requests
    output logic                         device_state_change_flag,
    output logic                         control_stage_change_flag,
    output logic                         buffer_ready_summary_flag,
    output logic                         buffer_not_ready_summary_flag,
    output logic                         irq_request
);
    // stored enables, cleared by hardware and software reset alike
    logic [`UEFS_SEL_W-1:0] select_q;                        // event select bits
    logic [NUM_EP-1:0]      per_endpoint_ready_enable_q;     // ready enable field
    logic [NUM_EP-1:0]      per_endpoint_not_ready_enable_q; // not-ready enable field

    // history of the endpoint flag levels, for edge detection
    logic [NUM_EP-1:0]      rdy_prev_q;                      // ready flags a cycle ago
    logic [NUM_EP-1:0]      nrdy_prev_q;                     // not-ready flags a cycle ago

    // register port decode
    logic                   sel_hit;                         // address is the select word
    logic                   rdy_hit;                         // address is the ready enables
    logic                   nrdy_hit;                        // address is the not-ready enables
    logic                   store_clear;                     // either reset clears storage
    uefs_pkg::uefs_word_t   rd_word;                         // read word before its register

    // per endpoint rising edges, before and after masking
    logic [NUM_EP-1:0]      rdy_rise;                        // ready flags that just rose
    logic [NUM_EP-1:0]      nrdy_rise;                       // not-ready flags that just rose
    logic [NUM_EP-1:0]      rdy_masked;                      // rose and enabled
    logic [NUM_EP-1:0]      nrdy_masked;                     // rose and enabled

    // set terms of the four summary flags
    logic                   dev_set;                         // device state flag sets
    logic                   ctl_set;                         // control stage flag sets
    logic                   rdy_set;                         // ready summary sets
    logic                   nrdy_set;                        // not-ready summary sets

    // interrupt terms, one for each summary flag
    logic                   dev_irq;                         // device state request
    logic                   ctl_irq;                         // control stage request
    logic                   rdy_irq;                         // ready summary request
    logic                   nrdy_irq;                        // not-ready summary request
    logic                   irq_d;                           // next interrupt request

    // address compare, shared by the write and the read decode
    // full address compare, so no alias of a register answers
    function automatic logic hit(input logic [`UEFS_ADDR_W-1:0] a,
                                 input logic [`UEFS_ADDR_W-1:0] o);
        hit = (a == o);
    endfunction

    // edge finder shared by both endpoint flag groups;
    // a flag that stays high is not a new event
    function automatic logic [NUM_EP-1:0] rise(input logic [NUM_EP-1:0] now,
                                               input logic [NUM_EP-1:0] prev);
        rise = now & ~prev;
    endfunction

    // address decode, used by writes and reads alike
    always_comb begin
        sel_hit     = hit(reg_addr, `UEFS_OFS_SELECT);
        rdy_hit     = hit(reg_addr, `UEFS_OFS_READY_EN);
        nrdy_hit    = hit(reg_addr, `UEFS_OFS_NREADY_EN);
        // a software reset clears the same storage as a hardware reset
        store_clear = !rst_b || soft_reset;
    end

    // event select bits; there is no bus reset input, so a bus reset
    // cannot disturb what software chose here
    always_ff @(posedge clk) begin
        if (store_clear) begin
            select_q <= '0;
        end else if (reg_wr && sel_hit) begin
            // upper bits of this word belong to enables held elsewhere
            select_q <= reg_wdata[`UEFS_SEL_W-1:0];
        end
    end

    // ready enable field, bit n kept for endpoint n
    always_ff @(posedge clk) begin
        if (store_clear) begin
            per_endpoint_ready_enable_q <= '0;
        end else if (reg_wr && rdy_hit) begin
            // reserved upper bits are dropped, so they always read back zero
            per_endpoint_ready_enable_q <= reg_wdata[NUM_EP-1:0];
        end
    end

    // not-ready enable field, bit n kept for endpoint n
    // limitation: isochronous endpoints are not masked here; the transfer
    // type is held elsewhere, so keeping their bits clear is up to software
    always_ff @(posedge clk) begin
        if (store_clear) begin
            per_endpoint_not_ready_enable_q <= '0;
        end else if (reg_wr && nrdy_hit) begin
            // reserved upper bits are dropped, so they always read back zero
            per_endpoint_not_ready_enable_q <= reg_wdata[NUM_EP-1:0];
        end
    end

    // read word: reserved and unmapped bits return zero
    always_comb begin
        rd_word = '0; // unmapped addresses fall through to zero
        if (sel_hit) begin // select bits in the low end
            rd_word[`UEFS_SEL_W-1:0] = select_q;
        end
        if (rdy_hit) begin // ready enables, upper bits stay zero
            rd_word[NUM_EP-1:0] = per_endpoint_ready_enable_q;
        end
        if (nrdy_hit) begin // not-ready enables, upper bits stay zero
            rd_word[NUM_EP-1:0] = per_endpoint_not_ready_enable_q;
        end
    end

    // read data register, holds its word until the next read strobe
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            reg_rdata <= `UEFS_RESET_VAL;
        end else if (reg_rd) begin // a read samples the stored value before any write
            reg_rdata <= rd_word;
        end
    end

    // history of the endpoint flags; cleared in reset so that a flag
    // already high when reset ends still counts as one event
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rdy_prev_q  <= '0;
            nrdy_prev_q <= '0;
        end else begin
            rdy_prev_q  <= per_endpoint_ready_flags;
            nrdy_prev_q <= per_endpoint_not_ready_flags;
        end
    end

    // rising edges of the endpoint flags, masked per endpoint
    always_comb begin
        rdy_rise    = rise(per_endpoint_ready_flags, rdy_prev_q);
        nrdy_rise   = rise(per_endpoint_not_ready_flags, nrdy_prev_q);
        rdy_masked  = rdy_rise & per_endpoint_ready_enable_q;
        nrdy_masked = nrdy_rise & per_endpoint_not_ready_enable_q;
        rdy_set     = |rdy_masked;
        nrdy_set    = |nrdy_masked;
    end

    // device state and control stage set terms, gated by the select bits;
    // setup completion bypasses the select bits on purpose
    always_comb begin
        dev_set = (ev_set_config & select_q[`UEFS_SEL_CFG])
                | (ev_suspend    & select_q[`UEFS_SEL_SUSPEND]);
        ctl_set = (ev_write_status   & select_q[`UEFS_SEL_WR_STATUS])
                | (ev_read_status    & select_q[`UEFS_SEL_RD_STATUS])
                | (ev_status_done    & select_q[`UEFS_SEL_DONE])
                | (ev_sequence_error & select_q[`UEFS_SEL_SEQ_ERR])
                | ev_setup_done;
    end

    // interrupt terms, each summary set gated by its own enable
    always_comb begin
        dev_irq  = dev_set & device_state_irq_enable;
        ctl_irq  = ctl_set & control_stage_irq_enable;
        rdy_irq  = rdy_set & ready_irq_enable;
        nrdy_irq = nrdy_set & not_ready_irq_enable;
        irq_d    = dev_irq | ctl_irq | rdy_irq | nrdy_irq;
    end

    // summary flag set pulses; registering them costs a cycle of latency
    // but keeps glitches of the event inputs off the outputs
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            // no pulse may leave the block while it is held in reset
            device_state_change_flag      <= 1'b0;
            control_stage_change_flag     <= 1'b0;
            buffer_ready_summary_flag     <= 1'b0;
            buffer_not_ready_summary_flag <= 1'b0;
        end else begin
            device_state_change_flag      <= dev_set;
            control_stage_change_flag     <= ctl_set;
            buffer_ready_summary_flag     <= rdy_set;
            buffer_not_ready_summary_flag <= nrdy_set;
        end
    end

    // interrupt request, in the same cycle as the pulse that causes it
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            irq_request <= 1'b0;
        end else begin // one term per summary flag
            irq_request <= irq_d;
        end
    end
endmodule
`default_nettype wire

//--- tb/uefs_es_properties.sv
// checker for the event flag enable select block
`timescale 1ns/1ps
`default_nettype none
module uefs_es_properties #(parameter int NUM_EP = 7) (
    input wire logic clk, rst_b, soft_reset, reg_wr, reg_rd, // clock, resets, strobes
    input wire logic [6:0] reg_addr,
    input wire uefs_pkg::uefs_word_t reg_wdata, reg_rdata,
    input wire logic ev_set_config, ev_suspend, ev_write_status, ev_read_status,
    input wire logic ev_status_done, ev_sequence_error, ev_setup_done,
    input wire logic [NUM_EP-1:0] per_endpoint_ready_flags, per_endpoint_not_ready_flags,
    input wire logic ready_irq_enable, not_ready_irq_enable,
    input wire logic device_state_irq_enable, control_stage_irq_enable,
    input wire logic device_state_change_flag, control_stage_change_flag,
    input wire logic buffer_ready_summary_flag, buffer_not_ready_summary_flag, irq_request);
    logic [5:0] s_q; // select shadow
    logic [6:0] r_q, n_q, pr_q, pn_q; // enable shadows, prior flags for edge detect
    wire [3:0] cev = {ev_write_status, ev_read_status, ev_status_done, ev_sequence_error};
    wire uefs_pkg::uefs_word_t rv = reg_addr == 7'h10 ? {10'h000, s_q} : reg_addr == 7'h12 ?
        {9'h000, r_q} : reg_addr == 7'h14 ? {9'h000, n_q} : 16'h0000; // unmapped reads zero
    // shadow the stored enables from the bus itself
    always_ff @(posedge clk) begin
        if (!rst_b) {pr_q, pn_q} <= '0;
        else {pr_q, pn_q} <= {per_endpoint_ready_flags, per_endpoint_not_ready_flags};
        if (!rst_b || soft_reset) {s_q, r_q, n_q} <= '0;
        else if (reg_wr && reg_addr == 7'h10) s_q <= reg_wdata[5:0];
        else if (reg_wr && reg_addr == 7'h12) r_q <= reg_wdata[6:0];
        else if (reg_wr && reg_addr == 7'h14) n_q <= reg_wdata[6:0];
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    AST_CFG: assert property (ev_set_config && !ev_suspend |=>
        device_state_change_flag == $past(s_q[5])) else $error("config gating wrong");
    AST_SUSPEND: assert property (ev_suspend && !ev_set_config |=>
        device_state_change_flag == $past(s_q[4])) else $error("suspend gating wrong");
    AST_CTL: assert property (1 |=> control_stage_change_flag ==
        $past(|(cev & s_q[3:0]) | ev_setup_done)) else $error("control gating wrong");
    AST_RDY: assert property (1 |=> buffer_ready_summary_flag ==
        $past(|(per_endpoint_ready_flags & ~pr_q & r_q))) else $error("ready summary wrong");
    AST_NRDY: assert property (1 |=> buffer_not_ready_summary_flag ==
        $past(|(per_endpoint_not_ready_flags & ~pn_q & n_q))) else $error("not ready wrong");
    AST_IRQ: assert property (irq_request == |({buffer_ready_summary_flag,
        buffer_not_ready_summary_flag, device_state_change_flag, control_stage_change_flag} &
        $past({ready_irq_enable, not_ready_irq_enable, device_state_irq_enable,
        control_stage_irq_enable}))) else $error("irq request wrong");
    AST_RES: assert property (reg_rd && reg_addr inside {7'h12, 7'h14} |=>
        reg_rdata[15:7] == 9'h000) else $error("reserved bits not zero");
    AST_RDV: assert property (reg_rd |=> reg_rdata == $past(rv))
        else $error("readback wrong");
    cover property (irq_request);
    cover property (buffer_not_ready_summary_flag);
    cover property (soft_reset ##1 reg_rd);
endmodule
bind uefs_enable_select uefs_es_properties #(.NUM_EP(NUM_EP)) u_uefs_es_properties (.*);
`default_nettype wire

//--- tb/uefs_host_model.sv
// host cpu model driving the register port
`timescale 1ns/1ps
`default_nettype none
module uefs_host_model #(parameter logic [6:0] ISO_EP = 7'h40) ( // isochronous endpoints
    input wire logic clk,
    output logic [6:0] reg_addr, output logic reg_wr, reg_rd,
    output var uefs_pkg::uefs_word_t reg_wdata);
    initial {reg_addr, reg_wr, reg_rd, reg_wdata} = '0;
    // one request per call, launched at the falling edge, held one clock
    task automatic op(input logic wr, rd, input logic [6:0] a, input uefs_pkg::uefs_word_t d);
        @(negedge clk);
        {reg_addr, reg_wr, reg_rd} = {a, wr, rd};
        reg_wdata = a == 7'h10 ? {10'h000, d[5:0]} : {9'h000, d[6:0]};
        if (a == 7'h14) reg_wdata[6:0] = d[6:0] & ~ISO_EP;
        if (!wr) reg_wdata = ~d; // idle data keeps moving
    endtask
endmodule
`default_nettype wire

//--- tb/tb_usb_event_flag_enable_select.sv
// testbench for the event flag enable select block
`timescale 1ns/1ps
`default_nettype none
module tb_usb_event_flag_enable_select;
    logic clk = 1'b0, rst_b = 1'b0, soft_reset = 1'b0, reg_wr, reg_rd; // clock, resets
    logic [6:0] ev = '0, rf = '0, nf = '0, prf = '0, pnf = '0, sr = '0, sn = '0, reg_addr, a;
    logic [5:0] ss = '0; // select shadow
    logic [3:0] en = '0; // irq enables
    wire logic [4:0] fl;    // flags and irq from the design, one driver per bit
    logic [4:0] ex_fl = '0; // flags and irq, expected
    logic [1:0] k; // 0 idle, 1 read, 2 and 3 write
    logic [6:0] tbl [4] = '{7'h10, 7'h12, 7'h14, 7'h20};
    uefs_pkg::uefs_word_t reg_wdata, reg_rdata, ex_rd = 16'h0000;
    int seed = 32'hc828, mismatches = 0, samples_checked = 0;
    uefs_enable_select u_uefs_enable_select (.clk, .rst_b, .soft_reset, .reg_addr, .reg_wr,
        .reg_rd, .reg_wdata, .reg_rdata, .ev_set_config(ev[6]), .ev_suspend(ev[5]),
        .ev_write_status(ev[4]), .ev_read_status(ev[3]), .ev_status_done(ev[2]),
        .ev_sequence_error(ev[1]), .ev_setup_done(ev[0]), .per_endpoint_ready_flags(rf),
        .per_endpoint_not_ready_flags(nf), .ready_irq_enable(en[3]), .not_ready_irq_enable(en[2]),
        .device_state_irq_enable(en[1]), .control_stage_irq_enable(en[0]),
        .device_state_change_flag(fl[4]), .control_stage_change_flag(fl[3]),
        .buffer_ready_summary_flag(fl[2]), .buffer_not_ready_summary_flag(fl[1]),
        .irq_request(fl[0]));
    uefs_host_model u_uefs_host_model (.clk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata);
    function automatic logic [31:0] rnd(); return $random(seed); endfunction
    function automatic uefs_pkg::uefs_word_t rval(input logic [6:0] ad); // readback
        return ad == 7'h10 ? {10'h000, ss} : ad == 7'h12 ? {9'h000, sr} :
            ad == 7'h14 ? {9'h000, sn} : 16'h0000;
    endfunction
    function automatic logic [4:0] fexp(); // flags after the next edge
        logic d, c, r, n;
        d = ev[6] & ss[5] | ev[5] & ss[4];
        c = |(ev[4:1] & ss[3:0]) | ev[0];
        r = |(rf & ~prf & sr);
        n = |(nf & ~pnf & sn);
        return {d, c, r, n, |({r, n, d, c} & en)};
    endfunction
    task automatic cmp_rd(input uefs_pkg::uefs_word_t g, e);
        samples_checked++;
        if (g !== e) begin mismatches++; $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end
    endtask
    task automatic cmp_fl(input logic [4:0] g, e);
        samples_checked++;
        if (g !== e) begin mismatches++; $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial forever #4 clk = ~clk;
    initial begin #100000; mismatches++; end_sim(); end // hang guard
    // reset reads, all-ones writes and readback, then random traffic
    initial begin
        repeat (16) @(negedge clk);
        rst_b = 1'b1;
        for (int i = 0; i < 3000; i++) begin
            a = i < 12 ? tbl[i % 4] : tbl[rnd() % 4];
            k = i < 4 || (i >= 8 && i < 12) ? 2'h1 : i < 12 ? 2'h2 : 2'(rnd());
            u_uefs_host_model.op(k[1], k == 2'h1, a, i < 12 ? 16'hFFFF : 16'(rnd()));
            cmp_fl(fl, ex_fl);
            cmp_rd(reg_rdata, ex_rd);
            if (i == 11) $display("test directed done");
            soft_reset = (rnd() & 63) == 0 && !reg_wr;
            {ev, rf, nf, en} = {7'(rnd() & rnd()), 7'(rnd()), 7'(rnd()), 4'(rnd())};
            ex_fl = fexp();
            {prf, pnf} = {rf, nf};
            if (reg_rd) ex_rd = rval(reg_addr);
            if (soft_reset) {ss, sr, sn} = '0;
            else if (reg_wr && reg_addr == 7'h10) ss = reg_wdata[5:0];
            else if (reg_wr && reg_addr == 7'h12) sr = reg_wdata[6:0];
            else if (reg_wr && reg_addr == 7'h14) sn = reg_wdata[6:0];
        end
        $display("test random done");
        end_sim();
    end
endmodule
`default_nettype wire
